// ---- rtl/bsr_pkg.sv ----
// Shared constants and types for the boundary-scan data register block
package bsr_pkg;

    // TAP controller states
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } bsr_tap_state_t;

    // Instruction codes
    localparam int           IR_W         = 3;
    localparam logic [2:0]   IR_EXTEST    = 3'h0;
    localparam logic [2:0]   IR_SAMPLE    = 3'h1;
    localparam logic [2:0]   IR_USER1     = 3'h2;
    localparam logic [2:0]   IR_USER2     = 3'h3;
    localparam logic [2:0]   IR_READBACK  = 3'h4;
    localparam logic [2:0]   IR_CONFIGURE = 3'h5;
    localparam logic [2:0]   IR_BYPASS    = 3'h7;
    localparam logic [2:0]   IR_CAPTURE   = 3'h1;

    // Boundary register layout
    localparam int BR_TEST_T_POS = 0;
    localparam int BR_TEST_O_POS = 1;
    localparam int BR_PIN_BASE   = 2;
    localparam int CELLS_PER_IOB = 3;
    localparam int CELL_IN       = 0;
    localparam int CELL_OUT      = 1;
    localparam int CELL_TS       = 2;
    localparam int BR_EXTRA      = 8;

    // Data path sizes
    localparam int CFG_W      = 8;
    localparam int FIFO_DEPTH = 8;

endpackage

// ---- rtl/bsr_top.sv ----
// Boundary-scan TAP, data registers, user chains and configuration word path
// Notes on behaviour
// - Each I/O block has in, out and 3-state cells.
// - Partial pins add only an in or out cell.
// - Reconfigure, config clock and done pins have no cells.
// - Capture-DR under EXTEST loads every pin cell at once.
// - Cell 0 is test 3-state, cell 1 test output.
// - Last cell is an update test cell driving a net.
// - Bypass is one flip-flop between TDI and TDO.
// - Bypass retimes data to TCK.
// - Each user select is high only for its own instruction.
// - A user instruction routes its user scan-out input to TDO.
// - User test logic gets a data-register clock.
// - Idle output is NAND of TCK and Run-Test/Idle.
// - Standard TAP state machine, instruction register, decodes.
// - Configure loads by scan; readback shifts it out.
// - Cells in each I/O block run input, output, then 3-state.
// - Mode pins zero, two add one cell; mode pin one adds three.
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Word FIFO
// ****************************************************************
module bsr_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_reg [D];
    logic [AW:0]  wptr_reg;
    logic [AW:0]  rptr_reg;
    logic         push;
    logic         pop;

    // Extra pointer bit tells full from empty
    assign in_ready_o  = (wptr_reg[AW-1:0] != rptr_reg[AW-1:0]) || (wptr_reg[AW] == rptr_reg[AW]);
    assign out_valid_o = wptr_reg != rptr_reg;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem_reg[rptr_reg[AW-1:0]];

    // Storage write
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wptr_reg[AW-1:0]] <= in_data_i;
        end
    end

    // Pointers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            wptr_reg <= wptr_reg + (AW+1)'(push);
            rptr_reg <= rptr_reg + (AW+1)'(pop);
        end
    end
endmodule

// ****************************************************************
// Top level
// ****************************************************************
module bsr_top import bsr_pkg::*; #(
    parameter int N_IOB = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             tck_i,
    input  wire logic             tms_i,
    input  wire logic             tdi_i,
    output logic                  tdo_o,
    output logic                  tdo_oe_o,
    input  wire logic [N_IOB-1:0] pad_in_i,
    output logic [N_IOB-1:0]      pad_out_o,
    output logic [N_IOB-1:0]      pad_oe_o,
    input  wire logic [N_IOB-1:0] core_out_i,
    input  wire logic [N_IOB-1:0] core_oe_i,
    input  wire logic             mode_pin_zero_i,
    input  wire logic             mode_pin_two_i,
    input  wire logic             mode_one_core_out_i,
    input  wire logic             mode_one_core_oe_i,
    output logic                  mode_pin_one_o,
    output logic                  mode_pin_one_oe_o,
    input  wire logic             test_tristate_i,
    input  wire logic             test_value_i,
    output logic                  scan_update_test_cell_o,
    output logic                  user_instr_one_select_o,
    output logic                  user_instr_two_select_o,
    input  wire logic             user_chain_one_scan_out_i,
    input  wire logic             user_chain_two_scan_out_i,
    output logic                  user_dr_shift_clock_o,
    output logic                  tap_idle_clock_nand_o,
    output logic                  user_shift_o,
    output logic                  user_update_o,
    output logic                  user_scan_in_o,
    input  wire logic             readback_bit_i,
    output logic                  readback_active_o,
    output logic [CFG_W-1:0]      cfg_word_o,
    output logic                  cfg_valid_o,
    input  wire logic             cfg_ready_i
);
    // Pin cells, mode pins (1 + 3 + 1), two test cells, update cell
    localparam int BR_LEN    = CELLS_PER_IOB * N_IOB + BR_EXTRA;
    localparam int MODE_BASE = BR_PIN_BASE + CELLS_PER_IOB * N_IOB;
    localparam int UPD_POS   = BR_LEN - 1;
    localparam int SW        = CELLS_PER_IOB * N_IOB + 7;
    localparam int CW        = $clog2(CFG_W);

    bsr_tap_state_t    st_reg;
    bsr_tap_state_t    st_next;
    logic              trst_a_reg;
    logic              trst_reg;
    logic [SW-1:0]     smp_a_reg;
    logic [SW-1:0]     smp_reg;
    logic [IR_W-1:0]   ir_reg;
    logic [IR_W-1:0]   ir_sr_reg;
    logic [BR_LEN-1:0] br_sr_reg;
    logic [BR_LEN-1:0] br_upd_reg;
    logic [BR_LEN-1:0] br_cap;
    logic              byp_reg;
    logic [CFG_W-1:0]  cfg_sr_reg;
    logic [CW-1:0]     cfg_cnt_reg;
    logic [CFG_W-1:0]  cfg_hold_reg;
    logic              cfg_tgl_reg;
    logic              ack_a_reg;
    logic              ack_reg;
    logic              dr_bit;
    logic              drck_en_reg;
    logic              tdo_reg;
    logic              tdo_oe_reg;
    logic              extest;
    logic              user_sel;
    logic              in_t0_reg;
    logic              in_t1_reg;
    logic              in_t2_reg;
    logic              pend_reg;
    logic              ack_tgl_reg;
    logic              push_ready;

    // ****************************************************************
    // TCK domain
    // ****************************************************************

    // Reset leaves in step with TCK; TMS also resets the TAP
    always_ff @(posedge tck_i or posedge rst_i) begin
        if (rst_i) begin
            trst_a_reg <= 1'b1;
            trst_reg   <= 1'b1;
        end else begin
            trst_a_reg <= 1'b0;
            trst_reg   <= trst_a_reg;
        end
    end

    // TAP next state
    always_comb begin
        unique case (st_reg)
            TLR:    st_next = tms_i ? TLR    : RTI;
            RTI:    st_next = tms_i ? SEL_DR : RTI;
            SEL_DR: st_next = tms_i ? SEL_IR : CAP_DR;
            CAP_DR: st_next = tms_i ? EX1_DR : SH_DR;
            SH_DR:  st_next = tms_i ? EX1_DR : SH_DR;
            EX1_DR: st_next = tms_i ? UPD_DR : PA_DR;
            PA_DR:  st_next = tms_i ? EX2_DR : PA_DR;
            EX2_DR: st_next = tms_i ? UPD_DR : SH_DR;
            UPD_DR: st_next = tms_i ? SEL_DR : RTI;
            SEL_IR: st_next = tms_i ? TLR    : CAP_IR;
            CAP_IR: st_next = tms_i ? EX1_IR : SH_IR;
            SH_IR:  st_next = tms_i ? EX1_IR : SH_IR;
            EX1_IR: st_next = tms_i ? UPD_IR : PA_IR;
            PA_IR:  st_next = tms_i ? EX2_IR : PA_IR;
            EX2_IR: st_next = tms_i ? UPD_IR : SH_IR;
            UPD_IR: st_next = tms_i ? SEL_DR : RTI;
        endcase
    end

    // State register; TMS high for five edges also reaches reset
    always_ff @(posedge tck_i or posedge trst_reg) begin
        if (trst_reg) begin
            st_reg <= TLR;
        end else begin
            st_reg <= st_next;
        end
    end

    // Instruction register: captures 001, resets to bypass
    always_ff @(posedge tck_i or posedge trst_reg) begin
        if (trst_reg) begin
            ir_sr_reg <= IR_CAPTURE;
            ir_reg    <= IR_BYPASS;
        end else begin
            if (st_reg == CAP_IR) begin
                ir_sr_reg <= IR_CAPTURE;
            end else if (st_reg == SH_IR) begin
                ir_sr_reg <= {tdi_i, ir_sr_reg[IR_W-1:1]};
            end
            if (st_reg == TLR) begin
                ir_reg <= IR_BYPASS;
            end else if (st_reg == UPD_IR) begin
                ir_reg <= ir_sr_reg;
            end
        end
    end

    assign extest   = ir_reg == IR_EXTEST;
    assign user_sel = (ir_reg == IR_USER1) || (ir_reg == IR_USER2);

    // Pin and core levels pass two TCK flops before capture
    always_ff @(posedge tck_i or posedge trst_reg) begin
        if (trst_reg) begin
            smp_a_reg <= '0;
            smp_reg   <= '0;
        end else begin
            smp_a_reg <= {readback_bit_i, test_value_i, test_tristate_i, mode_pin_two_i,
                          mode_one_core_oe_i, mode_one_core_out_i, mode_pin_zero_i,
                          core_oe_i, core_out_i, pad_in_i};
            smp_reg   <= smp_a_reg;
        end
    end

    // Capture image; reconfigure, config clock and done pins have no cells
    always_comb begin
        br_cap = '0;
        br_cap[BR_TEST_T_POS] = smp_reg[SW-3];
        br_cap[BR_TEST_O_POS] = smp_reg[SW-2];
        for (int i = 0; i < N_IOB; i++) begin
            br_cap[BR_PIN_BASE + CELLS_PER_IOB*i + CELL_IN]  = smp_reg[i];
            br_cap[BR_PIN_BASE + CELLS_PER_IOB*i + CELL_OUT] = smp_reg[N_IOB + i];
            br_cap[BR_PIN_BASE + CELLS_PER_IOB*i + CELL_TS]  = smp_reg[2*N_IOB + i];
        end
        br_cap[MODE_BASE]     = smp_reg[3*N_IOB];
        br_cap[MODE_BASE + 1] = smp_reg[3*N_IOB + 1];
        br_cap[MODE_BASE + 2] = smp_reg[3*N_IOB + 1];
        br_cap[MODE_BASE + 3] = smp_reg[3*N_IOB + 2];
        br_cap[MODE_BASE + 4] = smp_reg[3*N_IOB + 3];
        br_cap[UPD_POS]       = br_upd_reg[UPD_POS];
    end

    // Boundary shift and update stages
    always_ff @(posedge tck_i or posedge trst_reg) begin
        if (trst_reg) begin
            br_sr_reg  <= '0;
            br_upd_reg <= '0;
        end else begin
            if (st_reg == CAP_DR && (extest || ir_reg == IR_SAMPLE)) begin
                br_sr_reg <= br_cap;
            end else if (st_reg == SH_DR && (extest || ir_reg == IR_SAMPLE)) begin
                br_sr_reg <= {tdi_i, br_sr_reg[BR_LEN-1:1]};
            end
            if (st_reg == UPD_DR && (extest || ir_reg == IR_SAMPLE)) begin
                br_upd_reg <= br_sr_reg;
            end
        end
    end

    // Bypass: one stage, captures zero
    always_ff @(posedge tck_i or posedge trst_reg) begin
        if (trst_reg) begin
            byp_reg <= 1'b0;
        end else if (st_reg == CAP_DR) begin
            byp_reg <= 1'b0;
        end else if (st_reg == SH_DR) begin
            byp_reg <= tdi_i;
        end
    end

    // Words gather LSB first; one finished before the last is
    // acknowledged is dropped, as TCK cannot be stalled
    always_ff @(posedge tck_i or posedge trst_reg) begin
        if (trst_reg) begin
            cfg_sr_reg   <= '0;
            cfg_cnt_reg  <= '0;
            cfg_hold_reg <= '0;
            cfg_tgl_reg  <= 1'b0;
            ack_a_reg    <= 1'b0;
            ack_reg      <= 1'b0;
        end else begin
            ack_a_reg <= ack_tgl_reg;
            ack_reg   <= ack_a_reg;
            if (st_reg == CAP_DR) begin
                cfg_cnt_reg <= '0;
            end else if (st_reg == SH_DR && ir_reg == IR_CONFIGURE) begin
                cfg_sr_reg  <= {tdi_i, cfg_sr_reg[CFG_W-1:1]};
                cfg_cnt_reg <= cfg_cnt_reg + CW'(1);
                if (cfg_cnt_reg == CW'(CFG_W - 1) && cfg_tgl_reg == ack_reg) begin
                    cfg_hold_reg <= {tdi_i, cfg_sr_reg[CFG_W-1:1]};
                    cfg_tgl_reg  <= ~cfg_tgl_reg;
                end
            end
        end
    end

    // Source for TDO in Shift-DR
    always_comb begin
        unique case (ir_reg)
            IR_EXTEST, IR_SAMPLE: dr_bit = br_sr_reg[0];
            IR_USER1:             dr_bit = user_chain_one_scan_out_i;
            IR_USER2:             dr_bit = user_chain_two_scan_out_i;
            IR_READBACK:          dr_bit = smp_reg[SW-1];
            IR_CONFIGURE:         dr_bit = cfg_sr_reg[0];
            default:              dr_bit = byp_reg;
        endcase
    end

    // TDO changes on the falling edge, as the standard expects
    always_ff @(negedge tck_i or posedge trst_reg) begin
        if (trst_reg) begin
            tdo_reg     <= 1'b0;
            tdo_oe_reg  <= 1'b0;
            drck_en_reg <= 1'b0;
        end else begin
            tdo_reg     <= (st_reg == SH_IR) ? ir_sr_reg[0] : dr_bit;
            tdo_oe_reg  <= (st_reg == SH_IR) || (st_reg == SH_DR);
            drck_en_reg <= user_sel && (st_reg == CAP_DR || st_reg == SH_DR);
        end
    end

    assign tdo_o    = tdo_reg;
    assign tdo_oe_o = tdo_oe_reg;

    // User chain controls; gate enable moves only while TCK is low
    assign user_instr_one_select_o = ir_reg == IR_USER1;
    assign user_instr_two_select_o = ir_reg == IR_USER2;
    assign user_dr_shift_clock_o   = tck_i | ~drck_en_reg;
    assign tap_idle_clock_nand_o   = ~(tck_i & (st_reg == RTI));
    assign user_shift_o            = user_sel && st_reg == SH_DR;
    assign user_update_o           = user_sel && st_reg == UPD_DR;
    assign user_scan_in_o          = tdi_i;
    assign readback_active_o       = ir_reg == IR_READBACK;
    assign scan_update_test_cell_o = br_upd_reg[UPD_POS];

    // Pads follow the update stage under EXTEST, else the core
    always_comb begin
        for (int i = 0; i < N_IOB; i++) begin
            pad_out_o[i] = extest ? br_upd_reg[BR_PIN_BASE + CELLS_PER_IOB*i + CELL_OUT]
                                  : core_out_i[i];
            pad_oe_o[i]  = extest ? br_upd_reg[BR_PIN_BASE + CELLS_PER_IOB*i + CELL_TS]
                                  : core_oe_i[i];
        end
        mode_pin_one_o    = extest ? br_upd_reg[MODE_BASE + 2] : mode_one_core_out_i;
        mode_pin_one_oe_o = extest ? br_upd_reg[MODE_BASE + 3] : mode_one_core_oe_i;
    end

    // ****************************************************************
    // System clock domain
    // ****************************************************************

    // Toggle crossing: word is held stable until acknowledged
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_t0_reg   <= 1'b0;
            in_t1_reg   <= 1'b0;
            in_t2_reg   <= 1'b0;
            pend_reg    <= 1'b0;
            ack_tgl_reg <= 1'b0;
        end else begin
            in_t0_reg <= cfg_tgl_reg;
            in_t1_reg <= in_t0_reg;
            in_t2_reg <= in_t1_reg;
            if (pend_reg && push_ready) begin
                pend_reg    <= 1'b0;
                ack_tgl_reg <= ~ack_tgl_reg;
            end else if (in_t1_reg != in_t2_reg) begin
                pend_reg <= 1'b1;
            end
        end
    end

    // Word buffer; a stalled consumer holds off the acknowledge
    bsr_fifo #(
        .W (CFG_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (pend_reg),
        .in_ready_o  (push_ready),
        .in_data_i   (cfg_hold_reg),
        .out_valid_o (cfg_valid_o),
        .out_ready_i (cfg_ready_i),
        .out_data_o  (cfg_word_o)
    );
endmodule

`default_nettype wire

// ---- verification/bsr_top_properties.sv ----
// Port-level checks on the boundary-scan block
`timescale 1ns/1ps
`default_nettype none
module bsr_top_checker import bsr_pkg::*; #(
    parameter int N_IOB = 4
) (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             tck_i,
    input wire logic             tdo_o,
    input wire logic             tdo_oe_o,
    input wire logic [N_IOB-1:0] pad_out_o,
    input wire logic [N_IOB-1:0] pad_oe_o,
    input wire logic [N_IOB-1:0] core_out_i,
    input wire logic [N_IOB-1:0] core_oe_i,
    input wire logic             user_instr_one_select_o,
    input wire logic             user_instr_two_select_o,
    input wire logic             user_chain_one_scan_out_i,
    input wire logic             user_chain_two_scan_out_i,
    input wire logic             user_dr_shift_clock_o,
    input wire logic             tap_idle_clock_nand_o,
    input wire logic             user_shift_o,
    input wire logic             readback_active_o,
    input wire logic [CFG_W-1:0] cfg_word_o,
    input wire logic             cfg_valid_o,
    input wire logic             cfg_ready_i
);
    // ****************************************************************
    // Checks per clock domain
    // ****************************************************************
    logic sel1;
    logic sel2;
    // Short aliases
    assign sel1 = user_instr_one_select_o;
    assign sel2 = user_instr_two_select_o;

    chk_sel_one_hot: assert property (@(posedge tck_i) disable iff (rst_i)
        !(sel1 && sel2)) else $error("both selects high");
    chk_idle_tck_low: assert property (@(posedge tck_i) disable iff (rst_i)
        tap_idle_clock_nand_o) else $error("idle low while tck low");
    chk_drck_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !(sel1 || sel2) |-> user_dr_shift_clock_o) else $error("drck moves");
    chk_drck_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        !user_dr_shift_clock_o |-> !tck_i) else $error("drck low with tck high");
    chk_user_one_tdo: assert property (@(posedge tck_i) disable iff (rst_i)
        sel1 && user_shift_o && $stable(user_chain_one_scan_out_i)
        |-> tdo_o == user_chain_one_scan_out_i) else $error("tdo not user one data");
    chk_user_two_tdo: assert property (@(posedge tck_i) disable iff (rst_i)
        sel2 && user_shift_o && $stable(user_chain_two_scan_out_i)
        |-> tdo_o == user_chain_two_scan_out_i) else $error("tdo not user two data");
    chk_pad_core_path: assert property (@(posedge clk_i) disable iff (rst_i)
        (sel1 || sel2 || readback_active_o) |-> pad_out_o == core_out_i
        && pad_oe_o == core_oe_i) else $error("pads not core");
    chk_rb_excl: assert property (@(posedge clk_i) disable iff (rst_i)
        readback_active_o |-> !sel1 && !sel2) else $error("readback with select");
    chk_cfg_word_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_valid_o && !cfg_ready_i |=> cfg_valid_o && $stable(cfg_word_o))
        else $error("word lost");
    chk_oe_in_shift: assert property (@(posedge tck_i) disable iff (rst_i)
        user_shift_o |-> tdo_oe_o) else $error("tdo not driven in shift");
    // Main scenarios are reached
    cov_user_one: cover property (@(posedge tck_i) sel1 && user_shift_o);
    cov_user_two: cover property (@(posedge tck_i) sel2 && user_shift_o);
    cov_cfg_pop: cover property (@(posedge clk_i) cfg_valid_o && cfg_ready_i);
endmodule

bind bsr_top bsr_top_checker #(.N_IOB(N_IOB)) chk (
    .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .core_out_i(core_out_i),
    .core_oe_i(core_oe_i), .user_instr_one_select_o(user_instr_one_select_o),
    .user_instr_two_select_o(user_instr_two_select_o),
    .user_chain_one_scan_out_i(user_chain_one_scan_out_i),
    .user_chain_two_scan_out_i(user_chain_two_scan_out_i),
    .user_dr_shift_clock_o(user_dr_shift_clock_o),
    .tap_idle_clock_nand_o(tap_idle_clock_nand_o), .user_shift_o(user_shift_o),
    .readback_active_o(readback_active_o), .cfg_word_o(cfg_word_o),
    .cfg_valid_o(cfg_valid_o), .cfg_ready_i(cfg_ready_i));
`default_nettype wire

// ---- verification/bsr_jtag_host.sv ----
// Test controller model driving the scan port
`timescale 1ns/1ps
`default_nettype none
module bsr_jtag_host (
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i
);
    // ****************************************************************
    // Scan port driver
    // ****************************************************************
    // TCK rests low, TMS high keeps the TAP in reset
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // One 64 ns TCK period; TDO taken before the rise
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #32;
        tdo = tdo_i;
        tck_o = 1'b1;
        #32;
        tck_o = 1'b0;
    endtask
    // TDI toggles outside shifts to expose stale samples
    task automatic nav(input logic tms);
        logic t;
        tick(tms, ~tdi_o, t);
    endtask
    // Five TMS-high edges reach Test-Logic-Reset from any state
    task automatic tap_reset();
        repeat (5) nav(1'b1);
        nav(1'b0);
    endtask
    // Scan from Run-Test/Idle back to it, LSB first
    task automatic scan(input logic ir, input int n, input logic [31:0] d,
                        output logic [31:0] q);
        nav(1'b1);
        if (ir) nav(1'b1);
        nav(1'b0);
        nav(1'b0);
        q = '0;
        for (int i = 0; i < n; i++) tick(i == n - 1, d[i], q[i]);
        nav(1'b1);
        nav(1'b0);
    endtask
endmodule
`default_nettype wire

// ---- verification/bsr_top_bench.sv ----
// Self-checking bench for the boundary-scan block
`timescale 1ns/1ps
`default_nettype none
module bsr_top_bench import bsr_pkg::*;;
    // ****************************************************************
    // Stimulus, instances and scenarios
    // ****************************************************************
    localparam int NB  = 4;
    localparam int BRL = CELLS_PER_IOB * NB + BR_EXTRA;
    localparam int MB  = BR_PIN_BASE + CELLS_PER_IOB * NB;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic             tck, tms, tdi, tdo, tdo_oe, m1_pin, m1_pin_oe, upd, sel1, sel2;
    logic             drck, idle, ushift, uupd, usin, rb_act, cfg_valid;
    logic [NB-1:0]    pad_in = 4'h5, core_out = 4'h3, core_oe = 4'h6, pad_out, pad_oe;
    logic             m0 = 1'b1, m2 = 1'b0, m1_out = 1'b1, m1_oe = 1'b0;
    logic             tt = 1'b1, tv = 1'b0, uc1 = 1'b0, uc2 = 1'b0, rb = 1'b1;
    logic             cfg_ready = 1'b0;
    logic [CFG_W-1:0] cfg_word;
    int               mismatches = 0;
    int               n_tests = 0;

    // 10 MHz system clock
    always #50 clk_i = ~clk_i;

    bsr_jtag_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
    bsr_top #(.N_IOB(NB)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pad_in_i(pad_in), .pad_out_o(pad_out),
        .pad_oe_o(pad_oe), .core_out_i(core_out), .core_oe_i(core_oe),
        .mode_pin_zero_i(m0), .mode_pin_two_i(m2), .mode_one_core_out_i(m1_out),
        .mode_one_core_oe_i(m1_oe), .mode_pin_one_o(m1_pin), .mode_pin_one_oe_o(m1_pin_oe),
        .test_tristate_i(tt), .test_value_i(tv), .scan_update_test_cell_o(upd),
        .user_instr_one_select_o(sel1), .user_instr_two_select_o(sel2),
        .user_chain_one_scan_out_i(uc1), .user_chain_two_scan_out_i(uc2),
        .user_dr_shift_clock_o(drck), .tap_idle_clock_nand_o(idle),
        .user_shift_o(ushift), .user_update_o(uupd), .user_scan_in_o(usin),
        .readback_bit_i(rb), .readback_active_o(rb_act), .cfg_word_o(cfg_word),
        .cfg_valid_o(cfg_valid), .cfg_ready_i(cfg_ready));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Expected boundary image from bench levels
    function automatic logic [31:0] br_exp(input logic [NB-1:0] o, input logic [NB-1:0] t,
                                           input logic mo, input logic mt, input logic u);
        logic [31:0] e;
        e = '0;
        e[BR_TEST_T_POS] = tt;
        e[BR_TEST_O_POS] = tv;
        for (int i = 0; i < NB; i++) begin
            e[BR_PIN_BASE + 3 * i + CELL_IN] = pad_in[i];
            e[BR_PIN_BASE + 3 * i + CELL_OUT] = o[i];
            e[BR_PIN_BASE + 3 * i + CELL_TS] = t[i];
        end
        e[MB] = m0;
        e[MB + 1] = mo;
        e[MB + 2] = mo;
        e[MB + 3] = mt;
        e[MB + 4] = m2;
        e[BRL - 1] = u;
        return e;
    endfunction
    task automatic load_ir(input logic [2:0] code);
        logic [31:0] q;
        host.scan(1'b1, IR_W, {29'h0, code}, q);
        check(q[2:0], IR_CAPTURE, "ir capture");
    endtask
    task automatic t_idle();
        fork
            host.nav(1'b0);
            begin
                #16 check(idle, 1'b1, "idle tck low");
                #32 check(idle, 1'b0, "idle tck high");
            end
        join
    endtask
    // Reserved code must behave as bypass too
    task automatic t_bypass();
        logic [31:0] q;
        for (int k = 0; k < 2; k++) begin
            load_ir(k ? 3'h6 : IR_BYPASS);
            host.scan(1'b0, 8, 32'hb5, q);
            check(q[7:0], 8'h6a, "bypass delay");
        end
    endtask
    task automatic t_user();
        logic [31:0] q;
        for (int u = 0; u < 2; u++) begin
            @(negedge clk_i);
            uc1 = (u == 0);
            uc2 = (u == 1);
            load_ir(u ? IR_USER2 : IR_USER1);
            check({sel1, sel2, rb_act}, u ? 3'h2 : 3'h4, "user select");
            host.scan(1'b0, 6, 32'h15, q);
            check(q[5:0], 6'h3f, "user scan out");
        end
        host.tap_reset();
        check({sel1, sel2}, 2'h0, "tms reset");
    endtask
    task automatic t_boundary();
        logic [31:0] q;
        logic [31:0] p;
        p = br_exp(4'h9, 4'hc, 1'b1, 1'b1, 1'b1);
        load_ir(IR_SAMPLE);
        host.scan(1'b0, BRL, 32'h0, q);
        check(q, br_exp(core_out, core_oe, m1_out, m1_oe, 1'b0), "sample");
        load_ir(IR_EXTEST);
        host.scan(1'b0, BRL, p, q);
        check({pad_out, pad_oe, m1_pin, m1_pin_oe, upd}, 11'h4e7, "extest drive");
        @(negedge clk_i);
        pad_in = 4'ha;
        host.nav(1'b0);
        host.scan(1'b0, BRL, p, q);
        check(q, br_exp(core_out, core_oe, m1_out, m1_oe, 1'b1), "extest capture");
    endtask
    task automatic wait_valid();
        for (int k = 0; k < 20 && cfg_valid !== 1'b1; k++) @(negedge clk_i);
        if (cfg_valid !== 1'b1) begin
            mismatches++;
            end_sim();
        end
    endtask
    // Nine words: the ninth waits in the crossing until a pop
    task automatic t_config();
        logic [31:0] q;
        load_ir(IR_CONFIGURE);
        for (int w = 0; w < FIFO_DEPTH + 1; w++) host.scan(1'b0, CFG_W, 32'h31 + w, q);
        repeat (6) @(negedge clk_i);
        for (int w = 0; w < FIFO_DEPTH + 1; w++) begin
            wait_valid();
            check(cfg_word, 8'h31 + w, "config word");
            cfg_ready = 1'b1;
            @(negedge clk_i);
            cfg_ready = 1'b0;
        end
        @(negedge clk_i);
        check(cfg_valid, 1'b0, "fifo empty");
        load_ir(IR_READBACK);
        check({rb_act, sel1, sel2}, 3'h4, "readback");
    endtask

    initial begin
        fork
            host.tap_reset();
            repeat (12) @(posedge clk_i);
        join
        @(negedge clk_i);
        rst_i = 1'b0;
        check({tdo_oe, sel1, sel2, cfg_valid, upd}, 5'h0, "reset state");
        host.tap_reset();
        t_idle();
        t_bypass();
        t_user();
        t_boundary();
        t_config();
        end_sim();
    end
endmodule
`default_nettype wire
